//--- design/vout_fault_pkg.sv
// Constants shared by the output-voltage fault response handler.
package vout_fault_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] A_OV0 = 8'h00;
	localparam logic [7:0] A_UV0 = 8'h04;
	localparam logic [7:0] A_OV1 = 8'h08;
	localparam logic [7:0] A_UV1 = 8'h0C;
	localparam logic [7:0] A_RCNT = 8'h10;
	localparam logic [7:0] A_RDLY = 8'h14;
	localparam logic [7:0] A_TOFF0 = 8'h18;
	localparam logic [7:0] A_TOFF1 = 8'h1C;
	localparam logic [7:0] A_CTRL = 8'h20;
	localparam logic [7:0] A_STAT = 8'h24;
	localparam logic [7:0] A_CLR = 8'h28;
	localparam logic [7:0] A_CHST = 8'h2C;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] OV_RESP_RST = 8'h80;
	localparam logic [7:0] UV_RESP_RST = 8'h7F;
	localparam logic [2:0] RCNT_RST = 3'h0;
	localparam logic [15:0] RDLY_RST = 16'h00C8;
	localparam logic [15:0] TOFF_RST = 16'h0000;

	// ------------------------------------------------------------
	// Response byte fields and control bits
	// ------------------------------------------------------------
	localparam int ACT_LSB = 6;
	localparam int RTY_LSB = 3;
	localparam int DLY_LSB = 0;
	localparam logic [1:0] ACT_IGNORE = 2'h0;
	localparam logic [1:0] ACT_RIDE = 2'h1;
	localparam int CTRL_ON_LSB = 0;
	localparam int CTRL_TRK_LSB = 2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 25;
	localparam int SAMPLE_NS = 12200;
	localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS;

	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_ON = 4'h2,
		ST_SEQOFF = 4'h4,
		ST_HOLD = 4'h8
	} chan_state_t;

endpackage : vout_fault_pkg

//--- design/vout_fault_response_handler.sv
// Two-channel output overvoltage/undervoltage fault response handler.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
module vout_fault_response_handler
	import vout_fault_pkg::*;
#(
	parameter int CYC_PER_MS = MS_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Fast supervisor faults and channel controls
	input wire logic [1:0] ov_fault,
	input wire logic [1:0] uv_fault,
	input wire logic [1:0] ext_fault,
	input wire logic [1:0] ctrl_pin,
	input wire logic bias_ok,
	// Channel enables, status and alert
	output logic [1:0] chan_en,
	output logic [3:0] vout_status,
	output logic alert_out_n
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		chan_state_t [1:0] st;
		logic [3:0][7:0] resp;
		logic [2:0] rcnt;
		logic [15:0] rdly;
		logic [1:0][15:0] toff;
		logic [1:0] op_on;
		logic [1:0] trk;
		logic [3:0] vstat;
		logic alert_n;
		logic [3:0][2:0] dg;
		logic [3:0][2:0] rty_lat;
		logic [1:0][2:0] rty_sel;
		logic [1:0][2:0] left;
		logic [1:0][15:0] tmr;
		logic [1:0] en;
		logic [15:0] ms_cnt;
		logic [8:0] smp_cnt;
		logic [31:0] prdata;
	} state_t;

	state_t q;
	state_t n;
	logic [3:0] flt;
	logic [3:0] qual;
	logic [3:0] trip;
	logic [1:0] on_req;
	logic ms_tick;
	logic smp_tick;
	logic wr_clr;
	logic any_set;

	function automatic logic [1:0] act_of(input logic [7:0] r);
		act_of = r[ACT_LSB +: 2];
	endfunction : act_of

	function automatic logic [2:0] rty_of(input logic [7:0] r);
		rty_of = r[RTY_LSB +: 3];
	endfunction : rty_of

	function automatic logic [2:0] dly_of(input logic [7:0] r);
		dly_of = r[DLY_LSB +: 3];
	endfunction : dly_of

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a <= A_CHST) && (a[1:0] == 2'h0);
	endfunction : addr_hit

	// Only the fast supervisor comparators feed the deglitch filters; ext_fault acts on the channels directly.
	assign flt = {uv_fault[1], ov_fault[1], uv_fault[0], ov_fault[0]};
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit(paddr);
	assign prdata = q.prdata;
	assign chan_en = q.en;
	assign vout_status = q.vstat;
	assign alert_out_n = q.alert_n;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = q;
		wr_clr = 1'b0;
		any_set = 1'b0;
		ms_tick = (q.ms_cnt == 16'(CYC_PER_MS - 1));
		smp_tick = (q.smp_cnt == 9'(SAMPLE_CYC - 1));
		n.ms_cnt = ms_tick ? 16'h0000 : q.ms_cnt + 16'h0001;
		n.smp_cnt = smp_tick ? 9'h000 : q.smp_cnt + 9'h001;
		// Register writes take effect in the access phase.
		if (psel && penable && pwrite) begin
			case (paddr)
				A_OV0: n.resp[0] = pwdata[7:0];
				A_UV0: n.resp[1] = pwdata[7:0];
				A_OV1: n.resp[2] = pwdata[7:0];
				A_UV1: n.resp[3] = pwdata[7:0];
				A_RCNT: n.rcnt = pwdata[2:0];
				A_RDLY: n.rdly = pwdata[15:0];
				A_TOFF0: n.toff[0] = pwdata[15:0];
				A_TOFF1: n.toff[1] = pwdata[15:0];
				A_CTRL: begin
					n.op_on = pwdata[CTRL_ON_LSB +: 2];
					n.trk = pwdata[CTRL_TRK_LSB +: 2];
				end
				A_CLR: wr_clr = 1'b1;
				default: ;
			endcase
		end
		// Clearing status never restarts a channel; a new fault wins.
		if (wr_clr) begin
			n.vstat = 4'h0;
			n.alert_n = 1'b1;
		end
		// Deglitch and qualify each fault source.
		for (int f = 0; f < 4; f++) begin
			if (smp_tick) begin
				if (!flt[f]) begin
					n.dg[f] = 3'h0;
				end else if (q.dg[f] != dly_of(q.resp[f])) begin
					n.dg[f] = q.dg[f] + 3'h1;
				end
			end
			qual[f] = flt[f] && (q.dg[f] == dly_of(q.resp[f]));
			trip[f] = (act_of(q.resp[f]) == ACT_RIDE && qual[f])
				|| (q.resp[f][ACT_LSB + 1] && flt[f]);
			if (qual[f] || trip[f]) begin
				n.vstat[f] = 1'b1;
				n.alert_n = 1'b0;
				any_set = 1'b1;
			end
		end
		// Per-channel power and retry sequencing.
		for (int c = 0; c < 2; c++) begin
			on_req[c] = ctrl_pin[c] && q.op_on[c] && bias_ok;
			case (q.st[c])
				ST_OFF: begin
					n.en[c] = 1'b0;
					n.tmr[c] = 16'h0000;
					if (on_req[c]) begin
						n.st[c] = ST_ON;
						n.en[c] = 1'b1;
						n.left[c] = q.rcnt;
						n.rty_lat[2*c] = rty_of(q.resp[2*c]);
						n.rty_lat[2*c+1] = rty_of(q.resp[2*c+1]);
					end
				end
				ST_ON: begin
					if (!on_req[c]) begin
						n.st[c] = ST_OFF;
						n.en[c] = 1'b0;
					end else if (trip[2*c] || trip[2*c+1] || ext_fault[c]) begin
						n.rty_sel[c] = trip[2*c] ? q.rty_lat[2*c]
							: q.rty_lat[2*c+1];
						if (ext_fault[c]) begin
							n.left[c] = 3'h0;
						end
						n.tmr[c] = 16'h0000;
						if (q.trk[c]) begin
							n.st[c] = ST_SEQOFF;
						end else begin
							n.st[c] = ST_HOLD;
							n.en[c] = 1'b0;
						end
					end
				end
				ST_SEQOFF: begin
					if (!on_req[c]) begin
						n.st[c] = ST_OFF;
						n.en[c] = 1'b0;
					end else begin
						if (ext_fault[c]) begin
							n.left[c] = 3'h0;
						end
						if (q.tmr[c] >= q.toff[c]) begin
							n.st[c] = ST_HOLD;
							n.en[c] = 1'b0;
							n.tmr[c] = 16'h0000;
						end else if (ms_tick) begin
							n.tmr[c] = q.tmr[c] + 16'h0001;
						end
					end
				end
				ST_HOLD: begin
					n.en[c] = 1'b0;
					if (!on_req[c]) begin
						n.st[c] = ST_OFF;
					end else if (ext_fault[c]) begin
						n.left[c] = 3'h0;
					end else if (q.rty_sel[c] != 3'h0
						&& q.left[c] != 3'h0) begin
						if (q.tmr[c] >= q.rdly) begin
							n.st[c] = ST_ON;
							n.en[c] = 1'b1;
							n.left[c] = q.left[c] - 3'h1;
							n.tmr[c] = 16'h0000;
						end else if (ms_tick) begin
							n.tmr[c] = q.tmr[c] + 16'h0001;
						end
					end
				end
				default: begin
					n.st[c] = ST_OFF;
					n.en[c] = 1'b0;
				end
			endcase
		end
		// Read data is captured in the setup phase.
		if (psel && !penable) begin
			case (paddr)
				A_OV0: n.prdata = {24'h000000, q.resp[0]};
				A_UV0: n.prdata = {24'h000000, q.resp[1]};
				A_OV1: n.prdata = {24'h000000, q.resp[2]};
				A_UV1: n.prdata = {24'h000000, q.resp[3]};
				A_RCNT: n.prdata = {29'h0000000, q.rcnt};
				A_RDLY: n.prdata = {16'h0000, q.rdly};
				A_TOFF0: n.prdata = {16'h0000, q.toff[0]};
				A_TOFF1: n.prdata = {16'h0000, q.toff[1]};
				A_CTRL: n.prdata = {28'h0000000, q.trk, q.op_on};
				A_STAT: n.prdata = {27'h0000000, ~q.alert_n, q.vstat};
				A_CHST: n.prdata = {16'h0000, q.left, q.en, q.st};
				default: n.prdata = 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.st <= {ST_OFF, ST_OFF};
			q.resp <= {UV_RESP_RST, OV_RESP_RST, UV_RESP_RST, OV_RESP_RST};
			q.rcnt <= RCNT_RST;
			q.rdly <= RDLY_RST;
			q.toff <= {TOFF_RST, TOFF_RST};
			q.alert_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_turn_on;
		q.st[0] == ST_OFF && on_req[0] ##1 q.st[0] == ST_ON;
	endsequence

	sequence s_trip_track;
		q.st[0] == ST_ON && on_req[0] && trip[0] && q.trk[0];
	endsequence

	AST_RUN_IGNORE: assert property (
		q.st[0] == ST_ON && on_req[0] && !ext_fault[0]
		&& act_of(q.resp[0]) == ACT_IGNORE
		&& act_of(q.resp[1]) == ACT_IGNORE |=> chan_en[0])
		else $error("channel dropped with ignore action");

	AST_IMMEDIATE: assert property (
		q.st[0] == ST_ON && on_req[0] && ov_fault[0] && !q.trk[0]
		&& q.resp[0][7] |=> !chan_en[0] && q.st[0] == ST_HOLD)
		else $error("immediate shutdown missed");

	AST_SEQ_OFF: assert property (
		s_trip_track |=> q.st[0] == ST_SEQOFF && chan_en[0])
		else $error("tracked shutdown did not sequence off");

	AST_NO_RETRY: assert property (
		q.st[0] == ST_HOLD && q.rty_sel[0] == 3'h0 && on_req[0]
		|=> q.st[0] == ST_HOLD && !chan_en[0])
		else $error("restart with zero retry field");

	AST_CMD_OFF: assert property (
		q.st[0] == ST_HOLD && !on_req[0] |=> q.st[0] == ST_OFF)
		else $error("command off did not end retries");

	AST_RELOAD: assert property (
		s_turn_on |-> q.left[0] == $past(q.rcnt) && chan_en[0])
		else $error("attempt counter not reloaded");

	AST_DG_RESET: assert property (
		smp_tick && !flt[1] |=> q.dg[1] == 3'h0)
		else $error("deglitch count kept after fault vanished");

	AST_ALERT: assert property (
		$rose(|q.vstat) |-> !alert_out_n)
		else $error("status set without alert");

	AST_CLEAR: assert property (
		wr_clr && !any_set |=> alert_out_n && vout_status == 4'h0
		&& $stable(q.st))
		else $error("clear faults misbehaved");

endmodule : vout_fault_response_handler

//--- dv/supply_model.sv
// Behavioural supply and fast supervisor seen by the fault handler.
`timescale 1ns/1ps
module supply_model (
	// Channel enables from the handler
	input wire logic [1:0] chan_en,
	// Faults the bench asks the supplies to show
	input wire logic [1:0] ov_inj,
	input wire logic [1:0] uv_inj,
	// Fast supervisor fault levels
	output logic [1:0] ov_fault,
	output logic [1:0] uv_fault
);
	// A supply that is switched off shows no output voltage fault.
	assign ov_fault = ov_inj & chan_en;
	assign uv_fault = uv_inj & chan_en;
endmodule : supply_model

//--- dv/tb_vout_fault_response_handler.sv
// Self-checking bench for the output-voltage fault response handler.
`timescale 1ns/1ps
module tb_vout_fault_response_handler;
	import vout_fault_pkg::*;
	localparam int MSC = 8;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic bias_ok, alert_out_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [1:0] ov_fault, uv_fault, ext_fault, ctrl_pin, chan_en;
	logic [1:0] ov_inj, uv_inj;
	logic [3:0] vout_status;
	int fails, n_compared;

	vout_fault_response_handler #(.CYC_PER_MS(MSC))
			vout_fault_response_handler_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ov_fault(ov_fault),
		.uv_fault(uv_fault), .ext_fault(ext_fault), .ctrl_pin(ctrl_pin),
		.bias_ok(bias_ok), .chan_en(chan_en), .vout_status(vout_status),
		.alert_out_n(alert_out_n));
	supply_model supply_model_inst (.chan_en(chan_en), .ov_inj(ov_inj),
		.uv_inj(uv_inj), .ov_fault(ov_fault), .uv_fault(uv_fault));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// Bus, compare and wait tasks
	// ------------------------------------------------------------
	task automatic end_sim();
		if (fails == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fails++;
			end_sim();
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus

	task automatic wait_en(input logic v, input int lim);
		int n;
		n = 0;
		while (chan_en[0] !== v && n < lim) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, chan_en[0]}, {31'h0, v});
		if (chan_en[0] !== v) begin
			end_sim();
		end
	endtask : wait_en

	task automatic toggle_on();
		@(posedge pclk);
		ctrl_pin <= 2'h2;
		@(posedge pclk);
		ctrl_pin <= 2'h3;
		wait_en(1'b1, 10);
	endtask : toggle_on

	task automatic fault_for(input int cyc);
		@(posedge pclk);
		ov_inj <= 2'h1;
		repeat (cyc) @(posedge pclk);
		ov_inj <= 2'h0;
	endtask : fault_for

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = 43'h0;
		{ov_inj, uv_inj, ext_fault} = 6'h0;
		ctrl_pin = 2'h3;
		bias_ok = 1'b1;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		bus(1'b0, A_OV0, 32'h0);
		chk(rdat, {24'h0, OV_RESP_RST});
		bus(1'b0, A_UV1, 32'h0);
		chk(rdat, {24'h0, UV_RESP_RST});
		bus(1'b0, A_RDLY, 32'h0);
		chk(rdat, {16'h0, RDLY_RST});
		bus(1'b0, 8'h30, 32'h0);
		chk({rdat[30:0], err}, 32'h1);
		bus(1'b1, A_CTRL, 32'h1);
		wait_en(1'b1, 10);
		@(posedge pclk);
		ov_inj <= 2'h1;
		wait_en(1'b0, 3);
		chk({31'h0, alert_out_n}, 32'h0);
		chk({28'h0, vout_status}, 32'h1);
		ov_inj <= 2'h0;
		repeat (2000) @(posedge pclk);
		chk({31'h0, chan_en[0]}, 32'h0);
		bus(1'b1, A_CLR, 32'h0);
		@(posedge pclk);
		chk({27'h0, alert_out_n, vout_status}, 32'h10);
		chk({31'h0, chan_en[0]}, 32'h0);
		toggle_on();
		bus(1'b1, A_OV0, 32'h0);
		bus(1'b1, A_UV0, 32'h0);
		fault_for(1500);
		chk({31'h0, chan_en[0]}, 32'h1);
		chk({28'h0, vout_status}, 32'h1);
		bus(1'b1, A_CLR, 32'h0);
		bus(1'b1, A_OV0, 32'h42);
		bus(1'b1, A_UV0, {24'h0, UV_RESP_RST});
		fault_for(400);
		repeat (600) @(posedge pclk);
		fault_for(400);
		chk({27'h0, alert_out_n, vout_status}, 32'h10);
		// The quiet gap holds a sample tick, so deglitching starts from zero.
		repeat (600) @(posedge pclk);
		ov_inj <= 2'h1;
		repeat (480) @(posedge pclk);
		chk({27'h0, alert_out_n, vout_status}, 32'h10);
		chk({31'h0, chan_en[0]}, 32'h1);
		wait_en(1'b0, 1500);
		chk({28'h0, vout_status}, 32'h1);
		ov_inj <= 2'h0;
		bus(1'b1, A_CLR, 32'h0);
		bus(1'b1, A_TOFF0, 32'h2);
		bus(1'b1, A_CTRL, 32'h5);
		bus(1'b1, A_OV0, 32'h80);
		toggle_on();
		fault_for(4);
		chk({31'h0, chan_en[0]}, 32'h1);
		wait_en(1'b0, 3 * MSC);
		bus(1'b1, A_CTRL, 32'h1);
		bus(1'b1, A_RCNT, 32'h1);
		bus(1'b1, A_RDLY, 32'h1);
		bus(1'b1, A_OV0, 32'h88);
		toggle_on();
		// A zero retry field written while on must wait for an off-then-on.
		bus(1'b1, A_OV0, 32'h80);
		ov_inj <= 2'h1;
		wait_en(1'b0, 3);
		wait_en(1'b1, 3 * MSC);
		wait_en(1'b0, 3);
		repeat (8 * MSC) @(posedge pclk);
		chk({31'h0, chan_en[0]}, 32'h0);
		ov_inj <= 2'h0;
		toggle_on();
		ext_fault <= 2'h1;
		wait_en(1'b0, 3);
		ext_fault <= 2'h0;
		repeat (4 * MSC) @(posedge pclk);
		chk({31'h0, chan_en[0]}, 32'h0);
		// Channel 1 under-voltage fault with an immediate action.
		bus(1'b1, A_CLR, 32'h0);
		bus(1'b1, A_UV1, 32'h80);
		bus(1'b1, A_CTRL, 32'h3);
		repeat (3) @(posedge pclk);
		chk({31'h0, chan_en[1]}, 32'h1);
		uv_inj <= 2'h2;
		repeat (3) @(posedge pclk);
		chk({31'h0, chan_en[1]}, 32'h0);
		chk({28'h0, vout_status}, 32'h8);
		chk({31'h0, alert_out_n}, 32'h0);
		end_sim();
	end
endmodule : tb_vout_fault_response_handler
